// [verilog/serial_ctrl_pkg.sv]
// Purpose: shared constants and types for the serial port control core
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   control register layout follows the bit-addressable byte
package serial_ctrl_pkg;

    localparam int unsigned ADDR_W = 12;

    // register byte addresses
    localparam logic [11:0] OFF_CTRL0   = 12'h420;
    localparam logic [11:0] OFF_CTRL1   = 12'h424;
    localparam logic [11:0] OFF_ADDR0   = 12'h428;
    localparam logic [11:0] OFF_ADDR1   = 12'h42c;
    localparam logic [11:0] OFF_IRQ_ST  = 12'h430;
    localparam logic [11:0] OFF_IRQ_CLR = 12'h434;
    localparam logic [11:0] OFF_IRQ_EN  = 12'h438;

    // control register fields
    localparam int unsigned BIT_MODE_HI = 7;
    localparam int unsigned BIT_MODE_LO = 6;
    localparam int unsigned BIT_MP_EN   = 5;
    localparam int unsigned BIT_RX_EN   = 4;
    localparam int unsigned BIT_TX9     = 3;
    localparam int unsigned BIT_RX9     = 2;
    localparam int unsigned BIT_TX_DONE = 1;
    localparam int unsigned BIT_RX_DONE = 0;

    // address register fields: mask in [15:8], address in [7:0]
    localparam int unsigned ADDR_LSB = 0;
    localparam int unsigned MASK_LSB = 8;

    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [3:0]  IRQ_RESET  = 4'h0;

    // irq bit per port p: rx at 2p, tx at 2p+1
    localparam int unsigned IRQ_RX = 0;
    localparam int unsigned IRQ_TX = 1;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        MODE_SHIFT = 2'b00,
        MODE_8BIT  = 2'b01,
        MODE_9FIX  = 2'b10,
        MODE_9VAR  = 2'b11
    } mode_type;

    // receiver report of one completed character
    typedef struct packed {
        logic       done;
        logic [7:0] data;
        logic       ninth;
    } rx_event_type;

    // shifter-facing control for one port: mode, tx ninth bit, receive enable
    typedef struct packed {
        mode_type mode;
        logic     tx_ninth;
        logic     rx_enable;
    } port_ctrl_type;

endpackage : serial_ctrl_pkg

// [verilog/serial_port_control.sv]
// Purpose: control and status core of two asynchronous serial ports
// Assumes: shifters and baud logic live outside and report events here
// Notes:   registers over AXI4-Lite; one level interrupt output
//
// How it works
// RQ1: two mode bits pick shift, 8-bit, 9-bit fixed or 9-bit variable.
// RQ2: 9-bit modes with multiproc enable drop rx flag when ninth bit is 0.
// RQ3: 8-bit mode with multiproc enable drops rx flag without valid stop.
// RQ4: 9-bit modes send the tx ninth control bit, single buffered.
// RQ5: rx ninth field gets ninth bit, or stop bit in 8-bit mode unfiltered.
// RQ6: tx done flag sets when transmitter accepts more; software clears.
// RQ7: rx done flag set at character end, filtered; only software clears.
// RQ8: characters are taken only while receive enable is set.
// RQ9: address characters carry ninth bit 1, data characters ninth bit 0.
// RQ10: given address is address AND mask; broadcast is address OR mask.
`timescale 1ns/1ps
`default_nettype none

module serial_port_control #(
    parameter int unsigned PORTS = 2
) (
    input  wire logic                               aclk,
    input  wire logic                               aresetn,
    input  wire logic [serial_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                               s_axi_awvalid,
    output logic                                    s_axi_awready,
    input  wire logic [31:0]                        s_axi_wdata,
    input  wire logic [3:0]                         s_axi_wstrb,
    input  wire logic                               s_axi_wvalid,
    output logic                                    s_axi_wready,
    output logic [1:0]                              s_axi_bresp,
    output logic                                    s_axi_bvalid,
    input  wire logic                               s_axi_bready,
    input  wire logic [serial_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                               s_axi_arvalid,
    output logic                                    s_axi_arready,
    output logic [31:0]                             s_axi_rdata,
    output logic [1:0]                              s_axi_rresp,
    output logic                                    s_axi_rvalid,
    input  wire logic                               s_axi_rready,
    input  wire serial_ctrl_pkg::rx_event_type [PORTS-1:0] rx_event,
    input  wire logic [PORTS-1:0]                   tx_ready,
    output serial_ctrl_pkg::port_ctrl_type [PORTS-1:0]     port_ctrl,
    output logic                                    irq
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [PORTS-1:0][7:0]  ctrl;
        logic [PORTS-1:0][15:0] addr;
        logic [3:0]             irq_st;
        logic [3:0]             irq_en;
        logic [PORTS-1:0]       tx_rdy_d;
        logic                   aw_held;
        logic [11:0]            aw_addr;
        logic                   w_held;
        logic [31:0]            w_data;
        logic [3:0]             w_strb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } state_type;

    state_type state_reg;
    state_type state_next;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic is_nine(input logic [7:0] c);
        is_nine = c[serial_ctrl_pkg::BIT_MODE_HI]; // see RQ1
    endfunction : is_nine

    function automatic logic [1:0] mode_of(input logic [7:0] c);
        mode_of = {c[serial_ctrl_pkg::BIT_MODE_HI],
                   c[serial_ctrl_pkg::BIT_MODE_LO]}; // see RQ1
    endfunction : mode_of

    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] nw,
                                         input logic       en);
        merge = en ? nw : old;
    endfunction : merge

    // address filter on an address character
    function automatic logic addr_hit(input logic [15:0] a,
                                      input logic [7:0]  d);
        logic [7:0] sa;
        logic [7:0] sm;
        logic [7:0] bc;
        sa = a[serial_ctrl_pkg::ADDR_LSB +: 8];
        sm = a[serial_ctrl_pkg::MASK_LSB +: 8];
        bc = sa | sm; // see RQ10
        addr_hit = (((d ^ sa) & sm) == 8'h00) ||
                   (((d ^ bc) & bc) == 8'h00); // see RQ10
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic        wr_fire;
    logic        rd_fire;
    logic [11:0] rd_addr;

    always_comb begin
        logic [1:0] md;
        logic       mp;
        logic       take;
        logic       keep;
        int unsigned p;
        md = 2'b00;
        mp = 1'b0;
        take = 1'b0;
        keep = 1'b0;
        p = 0;
        state_next = state_reg;
        rd_addr = s_axi_araddr;

        // write channel capture
        if (s_axi_awvalid && !state_reg.aw_held) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_reg.w_held) begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        wr_fire = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
        rd_fire = s_axi_arvalid && !state_reg.rvalid;

        // software writes
        if (wr_fire) begin
            state_next.aw_held = 1'b0;
            state_next.w_held  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = serial_ctrl_pkg::RESP_OKAY;
            unique case (state_reg.aw_addr)
                serial_ctrl_pkg::OFF_CTRL0:
                    state_next.ctrl[0] = merge(state_reg.ctrl[0],
                        state_reg.w_data[7:0], state_reg.w_strb[0]);
                serial_ctrl_pkg::OFF_CTRL1:
                    state_next.ctrl[1] = merge(state_reg.ctrl[1],
                        state_reg.w_data[7:0], state_reg.w_strb[0]);
                serial_ctrl_pkg::OFF_ADDR0:
                    state_next.addr[0] = {
                        merge(state_reg.addr[0][15:8],
                              state_reg.w_data[15:8], state_reg.w_strb[1]),
                        merge(state_reg.addr[0][7:0],
                              state_reg.w_data[7:0], state_reg.w_strb[0])};
                serial_ctrl_pkg::OFF_ADDR1:
                    state_next.addr[1] = {
                        merge(state_reg.addr[1][15:8],
                              state_reg.w_data[15:8], state_reg.w_strb[1]),
                        merge(state_reg.addr[1][7:0],
                              state_reg.w_data[7:0], state_reg.w_strb[0])};
                serial_ctrl_pkg::OFF_IRQ_CLR:
                    if (state_reg.w_strb[0]) begin
                        state_next.irq_st = state_reg.irq_st
                                          & ~state_reg.w_data[3:0];
                    end
                serial_ctrl_pkg::OFF_IRQ_EN:
                    if (state_reg.w_strb[0]) begin
                        state_next.irq_en = state_reg.w_data[3:0];
                    end
                serial_ctrl_pkg::OFF_IRQ_ST: ;
                default:
                    state_next.bresp = serial_ctrl_pkg::RESP_SLVERR;
            endcase
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // hardware events; applied after writes so a set wins a clear
        for (p = 0; p < PORTS; p++) begin
            md = mode_of(state_reg.ctrl[p]);
            mp = state_reg.ctrl[p][serial_ctrl_pkg::BIT_MP_EN];
            // rising tx_ready: transmitter can take another byte
            if (tx_ready[p] && !state_reg.tx_rdy_d[p]) begin
                state_next.ctrl[p][serial_ctrl_pkg::BIT_TX_DONE] = 1'b1; // see RQ6
                state_next.irq_st[2*p+serial_ctrl_pkg::IRQ_TX] = 1'b1;
            end
            take = rx_event[p].done
                 && state_reg.ctrl[p][serial_ctrl_pkg::BIT_RX_EN]; // see RQ8
            keep = 1'b1;
            if (mp && is_nine(state_reg.ctrl[p])) begin
                keep = rx_event[p].ninth
                     && addr_hit(state_reg.addr[p], rx_event[p].data); // see RQ2
            end else if (mp && md == serial_ctrl_pkg::MODE_8BIT) begin
                keep = rx_event[p].ninth; // see RQ3
            end
            if (take && keep) begin
                if (md != serial_ctrl_pkg::MODE_SHIFT) begin
                    state_next.ctrl[p][serial_ctrl_pkg::BIT_RX9] =
                        rx_event[p].ninth; // see RQ5
                end
                state_next.ctrl[p][serial_ctrl_pkg::BIT_RX_DONE] = 1'b1; // see RQ7
                state_next.irq_st[2*p+serial_ctrl_pkg::IRQ_RX] = 1'b1;
            end
        end
        state_next.tx_rdy_d = tx_ready;

        // reads
        if (rd_fire) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = serial_ctrl_pkg::RESP_OKAY;
            state_next.rdata  = 32'h0000_0000;
            unique case (rd_addr)
                serial_ctrl_pkg::OFF_CTRL0:
                    state_next.rdata[7:0] = state_reg.ctrl[0];
                serial_ctrl_pkg::OFF_CTRL1:
                    state_next.rdata[7:0] = state_reg.ctrl[1];
                serial_ctrl_pkg::OFF_ADDR0:
                    state_next.rdata[15:0] = state_reg.addr[0];
                serial_ctrl_pkg::OFF_ADDR1:
                    state_next.rdata[15:0] = state_reg.addr[1];
                serial_ctrl_pkg::OFF_IRQ_ST:
                    state_next.rdata[3:0] = state_reg.irq_st;
                serial_ctrl_pkg::OFF_IRQ_EN:
                    state_next.rdata[3:0] = state_reg.irq_en;
                serial_ctrl_pkg::OFF_IRQ_CLR: ;
                default:
                    state_next.rresp = serial_ctrl_pkg::RESP_SLVERR;
            endcase
        end else if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg         <= '0;
            state_reg.irq_st  <= serial_ctrl_pkg::IRQ_RESET;
            state_reg.irq_en  <= serial_ctrl_pkg::IRQ_RESET;
            for (int i = 0; i < PORTS; i++) begin
                state_reg.ctrl[i] <= serial_ctrl_pkg::CTRL_RESET;
                state_reg.addr[i] <= serial_ctrl_pkg::ADDR_RESET;
            end
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign s_axi_awready = !state_reg.aw_held;
    assign s_axi_wready  = !state_reg.w_held;
    assign s_axi_bvalid  = state_reg.bvalid;
    assign s_axi_bresp   = state_reg.bresp;
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_rvalid  = state_reg.rvalid;
    assign s_axi_rdata   = state_reg.rdata;
    assign s_axi_rresp   = state_reg.rresp;
    assign irq = |(state_reg.irq_st & state_reg.irq_en);

    genvar g;
    generate
        for (g = 0; g < PORTS; g++) begin : g_port
            assign port_ctrl[g].mode = serial_ctrl_pkg::mode_type'(
                mode_of(state_reg.ctrl[g])); // see RQ1
            assign port_ctrl[g].tx_ninth =
                state_reg.ctrl[g][serial_ctrl_pkg::BIT_TX9]; // see RQ4 RQ9
            assign port_ctrl[g].rx_enable =
                state_reg.ctrl[g][serial_ctrl_pkg::BIT_RX_EN]; // see RQ8
        end
    endgenerate

endmodule : serial_port_control

`default_nettype wire

// [testbench/serial_port_control_chk.sv]
// Purpose: port checks of the serial control core
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every serial_port_control
`timescale 1ns/1ps
`default_nettype none
module serial_port_control_chk #(
    parameter int unsigned PORTS = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire serial_ctrl_pkg::rx_event_type [PORTS-1:0] rx_event,
    input wire logic [PORTS-1:0] tx_ready,
    input wire serial_ctrl_pkg::port_ctrl_type [PORTS-1:0] port_ctrl,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [PORTS-1:0] txr_q;
    logic             cause;
    logic             wr_take;
    always_ff @(posedge aclk) begin
        txr_q <= tx_ready;
    end
    always_comb begin
        cause = |(tx_ready & ~txr_q);
        for (int p = 0; p < PORTS; p++) begin
            cause = cause | rx_event[p].done;
        end
    end
    assign wr_take = s_axi_wvalid && s_axi_wready;
    ////////////////////////////////////////////////////////////////////////
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        wr_take |-> ##[1:2] s_axi_bvalid) else $error("no write response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("no read response");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_resp_drop: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("write response repeated");
    a_rdata_drop: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("read data repeated");
    a_ctrl_by_sw: assert property ($changed(port_ctrl)
        |-> $past(wr_take) || $past(wr_take, 2))
        else $error("port control changed without write");
    a_irq_cause: assert property ($rose(irq)
        |-> $past(cause) || $past(wr_take) || $past(wr_take, 2))
        else $error("irq rose without event");
    a_irq_clear: assert property ($fell(irq)
        |-> $past(wr_take) || $past(wr_take, 2))
        else $error("irq fell without write");
    a_reset_quiet: assert property ($rose(aresetn)
        |-> port_ctrl == '0 && !irq && s_axi_awready && !s_axi_bvalid)
        else $error("outputs not at reset values");
    c_irq_up: cover property ($rose(irq));
    c_irq_down: cover property ($fell(irq));
    c_rx_nine: cover property (rx_event[0].done &&
        port_ctrl[0].mode == serial_ctrl_pkg::MODE_9FIX);
endmodule : serial_port_control_chk
bind serial_port_control serial_port_control_chk #(.PORTS(PORTS)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rx_event(rx_event),
    .tx_ready(tx_ready), .port_ctrl(port_ctrl), .irq(irq));
`default_nettype wire

// [testbench/serial_peer_model.sv]
// Purpose: remote serial node as seen by the control core
// Assumes: events come in the core clock domain
// Notes:   idle data shows the inverse of the last character
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model #(
    parameter int unsigned PORTS = 2
) (
    input  wire logic                                      aclk,
    output var serial_ctrl_pkg::rx_event_type [PORTS-1:0] rx_event,
    output var logic [PORTS-1:0]                           tx_ready
);
    initial begin
        rx_event = '0;
        tx_ready = '0;
    end
    // one character after gap idle cycles; addr marks an address character
    task automatic send(input int p, input logic [7:0] d, input logic addr,
                        input int gap);
        @(posedge aclk);
        repeat (gap) @(posedge aclk);
        rx_event[p] <= '{done: 1'b1, data: d, ninth: addr};
        @(posedge aclk);
        rx_event[p] <= '{done: 1'b0, data: ~d, ninth: ~addr};
    endtask : send
    task automatic set_tx(input int p, input logic v);
        @(posedge aclk);
        tx_ready[p] <= v;
    endtask : set_tx
endmodule : serial_peer_model
`default_nettype wire

// [testbench/serial_port_control_tb.sv]
// Purpose: self-checking bench of the serial control core
// Assumes: AXI4-Lite master with bready and rready held high
// Notes:   one task per scenario
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        n_tests++; \
        if ((got) !== (ex)) begin \
            n_mismatch++; \
            $display("[FAIL] %s exp %0h got %0h", nm, ex, got); \
        end \
    end
module uart_serial_port_control_tb;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdv;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp, tx_ready;
    int          n_mismatch = 0, n_tests = 0;
    serial_ctrl_pkg::rx_event_type [1:0]  rx_event;
    serial_ctrl_pkg::port_ctrl_type [1:0] port_ctrl;
    localparam logic [14:0] RX_CASES [11] = '{15'h4a55, 15'h57a5,
        15'h5833, 15'h6811, 15'h7f42, 15'h62c3, 15'h3499, 15'h6fc2,
        15'h6c01, 15'h6fff, 15'h6cc1};
    always #10 aclk = ~aclk;
    serial_port_control #(.PORTS(2)) uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(1'b1), .rx_event(rx_event), .tx_ready(tx_ready),
        .port_ctrl(port_ctrl), .irq(irq));
    serial_peer_model #(.PORTS(2)) peer (.aclk(aclk),
        .rx_event(rx_event), .tx_ready(tx_ready));
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic aw, w, b;
        b = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (int i = 0; i < 40 && !b; i++) begin
            @(negedge aclk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        if (!b) begin
            n_mismatch++;
            results();
        end
    endtask : wr
    task automatic rd(input logic [11:0] a);
        logic ar, r;
        r = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int i = 0; i < 40 && !r; i++) begin
            @(negedge aclk);
            ar = s_axi_arvalid & s_axi_arready;
            r = s_axi_rvalid;
            rdv = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        if (!r) begin
            n_mismatch++;
            results();
        end
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(serial_ctrl_pkg::OFF_CTRL1);
        `CHK("ctrl1", 32'h0, rdv)
        `CHK("read ok", serial_ctrl_pkg::RESP_OKAY, resp)
        rd(12'h43c);
        `CHK("unmapped read", serial_ctrl_pkg::RESP_SLVERR, resp)
        wr(12'h43c, 32'hff);
        `CHK("unmapped", serial_ctrl_pkg::RESP_SLVERR, resp)
        rd(serial_ctrl_pkg::OFF_IRQ_CLR);
        `CHK("clear reg", 32'h0, rdv)
        $display("test reset done");
    endtask : t_reset
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wr(serial_ctrl_pkg::OFF_CTRL1, {24'h0, 2'(m), 6'h08});
            `CHK("mode", 2'(m), port_ctrl[1].mode)
            `CHK("tx ninth", 1'b1, port_ctrl[1].tx_ninth)
            rd(serial_ctrl_pkg::OFF_CTRL1);
            `CHK("ctrl1", {24'h0, 2'(m), 6'h08}, rdv)
        end
        wr(serial_ctrl_pkg::OFF_CTRL1, 32'h0);
        `CHK("tx ninth", 1'b0, port_ctrl[1].tx_ninth)
        $display("test modes done");
    endtask : t_modes
    task automatic t_rx();
        logic [14:0] c;
        for (int i = 0; i < 11; i++) begin
            c = RX_CASES[i];
            if (i == 7) wr(serial_ctrl_pkg::OFF_ADDR0, 32'hfdc0);
            wr(serial_ctrl_pkg::OFF_CTRL0, {24'h0, c[13:11], c[14], 4'h0});
            peer.send(0, c[7:0], c[10], i % 3);
            repeat (2) @(posedge aclk);
            rd(serial_ctrl_pkg::OFF_CTRL0);
            `CHK("rx flag", c[9], rdv[0])
            `CHK("rx ninth", c[8], rdv[2])
        end
        $display("test receive done");
    endtask : t_rx
    task automatic t_irq();
        wr(serial_ctrl_pkg::OFF_IRQ_CLR, 32'hf);
        wr(serial_ctrl_pkg::OFF_CTRL0, 32'h0);
        wr(serial_ctrl_pkg::OFF_IRQ_EN, 32'h6);
        peer.set_tx(0, 1'b1);
        repeat (4) @(posedge aclk);
        `CHK("irq tx", 1'b1, irq)
        wr(serial_ctrl_pkg::OFF_IRQ_ST, 32'h0);
        rd(serial_ctrl_pkg::OFF_IRQ_ST);
        `CHK("status", 32'h2, rdv)
        wr(serial_ctrl_pkg::OFF_IRQ_EN, 32'h0);
        `CHK("irq masked", 1'b0, irq)
        wr(serial_ctrl_pkg::OFF_IRQ_CLR, 32'h2);
        wr(serial_ctrl_pkg::OFF_IRQ_EN, 32'h6);
        `CHK("irq cleared", 1'b0, irq)
        rd(serial_ctrl_pkg::OFF_CTRL0);
        `CHK("tx flag", 1'b1, rdv[1])
        wr(serial_ctrl_pkg::OFF_CTRL0, 32'h0);
        rd(serial_ctrl_pkg::OFF_CTRL0);
        `CHK("tx flag", 1'b0, rdv[1])
        wr(serial_ctrl_pkg::OFF_CTRL1, 32'h10);
        `CHK("rx enable", 1'b1, port_ctrl[1].rx_enable)
        peer.send(1, 8'h3c, 1'b1, 5);
        repeat (2) @(posedge aclk);
        `CHK("irq rx1", 1'b1, irq)
        wr(serial_ctrl_pkg::OFF_IRQ_CLR, 32'h4);
        `CHK("irq off", 1'b0, irq)
        $display("test interrupts done");
    endtask : t_irq
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_modes();
        t_rx();
        t_irq();
        results();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        results();
    end
endmodule : uart_serial_port_control_tb
`default_nettype wire
